// ===== hw/sct_pkg.sv
// Constants and types shared by the converter timing control
package sct_pkg;

  // Register bus geometry
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 8;
  localparam int          NUM_SETS       = 4;
  localparam int          SEL_W          = 2;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_TSET_BASE  = 8'h10;
  localparam logic [7:0]  OFF_CHAN_BASE  = 8'h40;

  // Field positions
  localparam int          CTRL_START_BIT = 0;
  localparam int          CTRL_CHAN_LSB  = 8;
  localparam int          TSET_PRE_LSB   = 0;
  localparam int          TSET_SMP_LSB   = 8;
  localparam int          CHAN_SEL_LSB   = 0;
  localparam int          CHAN_PCE_BIT   = 2;
  localparam int          CHAN_RES10_BIT = 3;
  localparam int          CHAN_W         = 4;

  // Reset values
  localparam logic [7:0]  TSET_PRE_RST   = 8'h02;
  localparam logic [7:0]  TSET_SMP_RST   = 8'h05;
  localparam logic [3:0]  CHAN_RST       = 4'h0;

  // Phase lengths in peripheral clock periods
  localparam logic [7:0]  PRECH_MIN      = 8'h02;
  localparam logic [7:0]  SAMP_MIN       = 8'h05;
  localparam logic [7:0]  EVAL_12B       = 8'h19;
  localparam logic [7:0]  EVAL_10B       = 8'h15;

  // Software side minimum times and their cycle counts at the clock rate
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          SMP10_MIN_NS   = 555;
  localparam int          SMP10_MIN_CYC  = (SMP10_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PRE12S_MIN_NS  = 540;
  localparam int          PRE12S_MIN_CYC = (PRE12S_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SMP12S_MIN_NS  = 1500;
  localparam int          SMP12S_MIN_CYC = (SMP12S_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PRE12F_MIN_NS  = 270;
  localparam int          PRE12F_MIN_CYC = (PRE12F_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SMP12F_MIN_NS  = 750;
  localparam int          SMP12F_MIN_CYC = (SMP12F_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion phases
  typedef enum logic [1:0] {SCT_IDLE, SCT_PRECH, SCT_SAMPLE, SCT_EVAL} sct_state_t;

endpackage

// ===== hw/sct_sar_timing.sv
// Phase timing control for a successive-approximation converter
`timescale 1ns/10ps
`default_nettype none

module sct_sar_timing #(
  parameter int NUM_CH = 8,                              // Number of channels
  parameter int CH_W   = 3                               // Channel index width
) (
  input  wire logic                       clk_in,        // Peripheral clock
  input  wire logic                       rst_b_in,      // Async reset, active low
  input  wire logic [sct_pkg::ADDR_W-1:0] addr_in,       // Register byte address
  input  wire logic [sct_pkg::DATA_W-1:0] wdata_in,      // Write data
  input  wire logic                       wr_in,         // Write strobe
  input  wire logic                       rd_in,         // Read strobe
  output logic      [sct_pkg::DATA_W-1:0] rdata_out,     // Read data, cycle after strobe
  output logic                            precharge_out, // Precharge phase active
  output logic                            sample_out,    // Sampling phase active
  output logic                            eval_out,      // Evaluation phase active
  output logic                            busy_out,      // Conversion in progress
  output logic                            done_out,      // One-cycle completion pulse
  output logic      [CH_W-1:0]            channel_out,   // Channel being converted
  output logic                            res10_out      // Current conversion is 10-bit
);
  import sct_pkg::*;

  // Configuration storage
  logic [CNT_W-1:0]  pre_q  [NUM_SETS];
  logic [CNT_W-1:0]  smp_q  [NUM_SETS];
  logic [CHAN_W-1:0] chan_q [NUM_CH];
  logic [CNT_W-1:0]  next_pre [NUM_SETS];
  logic [CNT_W-1:0]  next_smp [NUM_SETS];
  logic [CHAN_W-1:0] next_chan [NUM_CH];

  // Sequencer state
  sct_state_t        state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [CNT_W-1:0]  samp_lat, next_samp_lat;
  logic [CNT_W-1:0]  pre_lat, next_pre_lat;
  logic [CH_W-1:0]   cur_ch, next_cur_ch;
  logic              cur_pce, next_cur_pce;
  logic              cur_res10, next_cur_res10;
  logic              done, next_done;
  logic [DATA_W-1:0] rdata, next_rdata;

  // Start decode and the configuration of the channel being started
  logic              start_req;
  logic [CH_W-1:0]   start_ch;
  logic [CHAN_W-1:0] start_cfg;
  logic [SEL_W-1:0]  start_sel;
  logic              start_pce;
  logic [CNT_W-1:0]  start_pre;
  logic [CNT_W-1:0]  start_samp;

  assign start_ch   = wdata_in[CTRL_CHAN_LSB +: CH_W];
  assign start_req  = wr_in && (addr_in == OFF_CTRL) && wdata_in[CTRL_START_BIT]
                      && (state == SCT_IDLE) && (int'(start_ch) < NUM_CH);
  assign start_cfg  = chan_q[start_ch];
  assign start_sel  = start_cfg[CHAN_SEL_LSB +: SEL_W];
  assign start_pce  = start_cfg[CHAN_PCE_BIT];
  // Clamp to the hardware minimum so a zero count can never stall the sequence
  assign start_pre  = (pre_q[start_sel] < PRECH_MIN) ? PRECH_MIN : pre_q[start_sel];
  assign start_samp = (smp_q[start_sel] < SAMP_MIN) ? SAMP_MIN : smp_q[start_sel];

  // Timing set registers, one word per set
  for (genvar g = 0; g < NUM_SETS; g++) begin : g_tset
    logic hit;
    assign hit         = wr_in && (addr_in == OFF_TSET_BASE + 8'(4 * g));
    assign next_pre[g] = hit ? wdata_in[TSET_PRE_LSB +: CNT_W] : pre_q[g];
    assign next_smp[g] = hit ? wdata_in[TSET_SMP_LSB +: CNT_W] : smp_q[g];
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        pre_q[g] <= TSET_PRE_RST;
        smp_q[g] <= TSET_SMP_RST;
      end else begin
        pre_q[g] <= next_pre[g];
        smp_q[g] <= next_smp[g];
      end
    end
  end

  // Channel data registers; a write mid-conversion affects only later starts
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    assign next_chan[c] = (wr_in && (addr_in == OFF_CHAN_BASE + 8'(4 * c)))
                          ? wdata_in[CHAN_W-1:0] : chan_q[c];
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        chan_q[c] <= CHAN_RST;
      end else begin
        chan_q[c] <= next_chan[c];
      end
    end
  end

  // Phase sequencer: counts down the current phase in clock periods
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_samp_lat  = samp_lat;
    next_pre_lat   = pre_lat;
    next_cur_ch    = cur_ch;
    next_cur_pce   = cur_pce;
    next_cur_res10 = cur_res10;
    next_done      = 1'b0;
    case (state)
      SCT_IDLE: begin
        if (start_req) begin
          // Counts are latched so later writes cannot stretch a running phase
          next_cur_ch    = start_ch;
          next_cur_pce   = start_pce;
          next_cur_res10 = start_cfg[CHAN_RES10_BIT];
          next_samp_lat  = start_samp;
          next_pre_lat   = start_pre;
          if (start_pce) begin
            next_state = SCT_PRECH;
            next_cnt   = start_pre - 8'h01;
          end else begin
            next_state = SCT_SAMPLE;
            next_cnt   = start_samp - 8'h01;
          end
        end
      end
      SCT_PRECH: begin
        if (cnt == '0) begin
          next_state = SCT_SAMPLE;
          next_cnt   = samp_lat - 8'h01;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      SCT_SAMPLE: begin
        if (cnt == '0) begin
          next_state = SCT_EVAL;
          next_cnt   = (cur_res10 ? EVAL_10B : EVAL_12B) - 8'h01;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      SCT_EVAL: begin
        if (cnt == '0) begin
          next_state = SCT_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        next_state = SCT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state     <= SCT_IDLE;
      cnt       <= '0;
      samp_lat  <= SAMP_MIN;
      pre_lat   <= PRECH_MIN;
      cur_ch    <= '0;
      cur_pce   <= 1'b0;
      cur_res10 <= 1'b0;
      done      <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      samp_lat  <= next_samp_lat;
      pre_lat   <= next_pre_lat;
      cur_ch    <= next_cur_ch;
      cur_pce   <= next_cur_pce;
      cur_res10 <= next_cur_res10;
      done      <= next_done;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    next_rdata = '0;
    if (rd_in) begin
      if (addr_in == OFF_STATUS) begin
        next_rdata[1:0]   = state;
        next_rdata[2]     = (state != SCT_IDLE);
        next_rdata[3]     = cur_res10;
        next_rdata[15:8]  = cnt;
        next_rdata[16 +: CH_W] = cur_ch;
      end
      for (int i = 0; i < NUM_SETS; i++) begin
        if (addr_in == OFF_TSET_BASE + 8'(4 * i)) begin
          next_rdata[TSET_PRE_LSB +: CNT_W] = pre_q[i];
          next_rdata[TSET_SMP_LSB +: CNT_W] = smp_q[i];
        end
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (addr_in == OFF_CHAN_BASE + 8'(4 * i)) begin
          next_rdata[CHAN_W-1:0] = chan_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Outputs straight from state flip-flops
  assign rdata_out     = rdata;
  assign precharge_out = (state == SCT_PRECH);
  assign sample_out    = (state == SCT_SAMPLE);
  assign eval_out      = (state == SCT_EVAL);
  assign busy_out      = (state != SCT_IDLE);
  assign done_out      = done;
  assign channel_out   = cur_ch;
  assign res10_out     = cur_res10;

  // Helper counters for the checks: cycles in phase and in conversion
  logic [8:0] phase_len;
  logic [8:0] conv_len;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_len <= '0;
      conv_len  <= '0;
    end else begin
      phase_len <= (state != next_state) ? 9'h000 : phase_len + 9'h001;
      conv_len  <= start_req ? 9'h000 : ((state != SCT_IDLE) ? conv_len + 9'h001 : conv_len);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence eval_end_s;
    (state == SCT_EVAL) ##1 (state == SCT_IDLE);
  endsequence
  sequence prech_end_s;
    (state == SCT_PRECH) && (next_state != SCT_PRECH);
  endsequence

  prech_enter_a: assert property (start_req && start_pce |=> state == SCT_PRECH)
    else $error("precharge not entered with precharge enabled");
  prech_len_a: assert property (prech_end_s |-> phase_len + 9'h001 == {1'b0, pre_lat})
    else $error("precharge length differs from programmed count");
  prech_min_a: assert property (prech_end_s |-> phase_len >= 9'h001)
    else $error("precharge shorter than two cycles");
  prech_skip_a: assert property (start_req && !start_pce |=> sample_out && phase_len == 9'h000)
    else $error("precharge not skipped");
  samp_len_a: assert property ((state == SCT_SAMPLE) && (next_state != SCT_SAMPLE)
      |-> phase_len + 9'h001 == {1'b0, samp_lat} && samp_lat >= SAMP_MIN)
    else $error("sampling length wrong or below five");
  eval_len_a: assert property ((state == SCT_EVAL) && (next_state != SCT_EVAL)
      |-> phase_len + 9'h001 == (cur_res10 ? 9'd21 : 9'd25))
    else $error("evaluation length wrong");
  set_sel_a: assert property (start_req |=> samp_lat == $past(start_samp))
    else $error("sample count not taken from selected set");
  conv_total_a: assert property (done_out |-> conv_len ==
      (cur_pce ? {1'b0, pre_lat} : 9'h000) + {1'b0, samp_lat} + (cur_res10 ? 9'd21 : 9'd25))
    else $error("total conversion time wrong");
  done_order_a: assert property (eval_end_s |-> done_out)
    else $error("done missing after evaluation");
  done_cause_a: assert property (done_out |-> $past(state) == SCT_EVAL)
    else $error("done without evaluation");

endmodule // sct_sar_timing

`default_nettype wire

// ===== bench/sct_mux_model.sv
// Analog input multiplexer model that follows the converter phases
`timescale 1ns/10ps
`default_nettype none
module sct_mux_model (
  input  wire logic       clk_in,         // Peripheral clock
  input  wire logic       rst_b_in,       // Async reset, active low
  input  wire logic       pre_in,         // Precharge phase
  input  wire logic       smp_in,         // Sampling phase
  input  wire logic       ev_in,          // Evaluation phase
  input  wire logic       busy_in,        // Conversion active
  output logic      [7:0] pre_len_out,    // Precharge cycles seen
  output logic      [7:0] smp_len_out,    // Sample cycles seen
  output logic      [7:0] ev_len_out,     // Evaluation cycles seen
  output logic            order_bad_out,  // A phase came out of turn
  output logic            slow_grant_out  // Shared input free for the slow converter
);
  logic busy_q; // Busy one cycle back

  // The slow converter never samples the shared input while this one does
  assign slow_grant_out = !smp_in;

  // Lengths restart on the first busy cycle, so back-to-back runs stay apart
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {busy_q, pre_len_out, smp_len_out, ev_len_out, order_bad_out} <= '0;
    end else begin
      busy_q <= busy_in;
      if (busy_in && !busy_q) begin
        pre_len_out   <= 8'(pre_in);
        smp_len_out   <= 8'(smp_in);
        ev_len_out    <= 8'(ev_in);
        order_bad_out <= ev_in;
      end else begin
        pre_len_out <= pre_len_out + 8'(pre_in);
        smp_len_out <= smp_len_out + 8'(smp_in);
        ev_len_out  <= ev_len_out + 8'(ev_in);
        if ((pre_in && (smp_len_out != 0 || ev_len_out != 0)) || (smp_in && ev_len_out != 0)) begin
          order_bad_out <= 1'b1;
        end
      end
    end
  end
endmodule // sct_mux_model
`default_nettype wire

// ===== bench/sct_sar_timing_tb.sv
// Self-checking bench for the converter phase timing
`timescale 1ns/10ps
`default_nettype none
module sct_sar_timing_tb;
  import sct_pkg::*;
  logic              clk_in, rst_b_in, wr_in, rd_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in, rdata_out;
  logic              pre_o, smp_o, ev_o, busy_o, done_o, res10_o, order_bad, grant;
  logic [2:0]        chan_o;
  logic [7:0]        pre_len, smp_len, ev_len;
  int                n_mismatch = 0, comparisons = 0, cyc = 0;
  // One row per timing set; rows 1 and 2 follow the software minimum times, row 3 only in its sample count
  logic [7:0] t_pre [4] = '{8'h01, 8'(PRE12F_MIN_CYC), 8'(PRE12S_MIN_CYC), 8'h02};
  logic [7:0] t_smp [4] = '{8'h04, 8'(SMP12F_MIN_CYC), 8'(SMP12S_MIN_CYC), 8'(SMP10_MIN_CYC)};
  logic       t_pce [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic       t_r10 [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  sct_sar_timing dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .precharge_out(pre_o), .sample_out(smp_o), .eval_out(ev_o), .busy_out(busy_o),
    .done_out(done_o), .channel_out(chan_o), .res10_out(res10_o));
  sct_mux_model mux (.clk_in(clk_in), .rst_b_in(rst_b_in), .pre_in(pre_o), .smp_in(smp_o),
    .ev_in(ev_o), .busy_in(busy_o), .pre_len_out(pre_len), .smp_len_out(smp_len),
    .ev_len_out(ev_len), .order_bad_out(order_bad), .slow_grant_out(grant));

  // Free clock and an edge counter for conversion times
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) cyc <= cyc + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic test_reset_values;
    logic [31:0] d;
    bus_rd(OFF_TSET_BASE, d);
    check("set0 reset", d, {16'h0000, TSET_SMP_RST, TSET_PRE_RST});
    bus_rd(OFF_CHAN_BASE, d);
    check("chan0 reset", d, 32'(CHAN_RST));
    bus_rd(8'h80, d);
    check("unmapped read", d, 32'h0000_0000);
    @(posedge clk_in);
    #1 check("read data idle", rdata_out, 32'h0000_0000);
  endtask

  // Four independent sets hold distinct values
  task automatic test_sets;
    logic [31:0] d;
    for (int i = 0; i < NUM_SETS; i++) bus_wr(OFF_TSET_BASE + 8'(4 * i), {16'h0, t_smp[i], t_pre[i]});
    for (int i = 0; i < NUM_SETS; i++) begin
      bus_rd(OFF_TSET_BASE + 8'(4 * i), d);
      check("set readback", d, {16'h0, t_smp[i], t_pre[i]});
    end
  endtask

  // Channel row+1 runs on set row; mid tries a restart and a set rewrite
  task automatic run_conv(input int row, input bit mid);
    int p, s, e, t0, ch;
    logic [31:0] d;
    ch = row + 1;
    p = t_pce[row] ? ((t_pre[row] < PRECH_MIN) ? PRECH_MIN : t_pre[row]) : 0;
    s = (t_smp[row] < SAMP_MIN) ? SAMP_MIN : t_smp[row];
    e = t_r10[row] ? EVAL_10B : EVAL_12B;
    bus_wr(OFF_CHAN_BASE + 8'(4 * ch), {28'h0, t_r10[row], t_pce[row], 2'(row)});
    bus_wr(OFF_CTRL, (32'(ch) << CTRL_CHAN_LSB) | 32'h1);
    #1 t0 = cyc;
    check("first phase", 32'({pre_o, smp_o}), t_pce[row] ? 32'h2 : 32'h1);
    // Shared input is withheld from the slow converter only while sampling
    check("slow grant", 32'(grant), 32'(t_pce[row]));
    // Every first phase lasts at least two cycles, so status still shows it
    bus_rd(OFF_STATUS, d);
    check("status", d & 32'h0007_000F,
      (32'(ch) << 16) | 32'({t_r10[row], 1'b1, t_pce[row] ? 2'h1 : 2'h2}));
    if (mid) begin
      bus_wr(OFF_TSET_BASE + 8'(4 * row), 32'h0000_0303);
      bus_wr(OFF_CTRL, 32'h0000_0001);
    end
    for (int k = 0; k < 400 && done_o !== 1'b1; k++) begin
      @(posedge clk_in);
      #1;
    end
    // A hang counts as a mismatch and the closing report still runs
    check("conversion done", 32'(done_o), 32'h1);
    if (done_o !== 1'b1) return;
    check("conversion time", 32'(cyc - t0 + 1), 32'(1 + p + s + e));
    check("busy in done", 32'(busy_o), 32'h0);
    check("precharge length", 32'(pre_len), 32'(p));
    check("sample length", 32'(smp_len), 32'(s));
    check("eval length", 32'(ev_len), 32'(e));
    check("phase order", 32'(order_bad), 32'h0);
    check("channel", 32'(chan_o), 32'(ch));
    check("resolution", 32'(res10_o), 32'(t_r10[row]));
    // Completion is a single-cycle pulse
    @(posedge clk_in);
    #1 check("done pulse", 32'(done_o), 32'h0);
  endtask

  initial begin
    rst_b_in = 1'b0;
    wr_in    = 1'b0;
    rd_in    = 1'b0;
    addr_in  = 8'h00;
    wdata_in = 32'h0000_0000;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    test_reset_values;
    test_sets;
    for (int r = 0; r < NUM_SETS; r++) run_conv(r, r == 2);
    report_and_stop;
  end
endmodule // sct_sar_timing_tb
`default_nettype wire
